// ==== hdl/csn_regs.sv ====
/*
 Charger status and thermistor profile register slice.
 Assumes the serial interface engine presents one register access per strobe
 on the same clock, and that all live condition inputs come from other domains.
*/
`timescale 1ns/1ps
//
// Overview of operation
// - Prewarm voltage field bits 5:4 lowers target 300/200/100 mV; code 3 unchanged.
// - Prewarm current field bits 3:2: suspend, 20%, 40%, or unchanged.
// - Precool current field bits 1:0, same encoding, default unchanged.
// - Condition status at 0x1d resets zero; bit 7 reserved, rest read only.
// - Bit 6 shows one-shot conversion done; always zero in continuous mode.
// - Bit 5 shows die thermal regulation.
// - Bit 4 shows minimum system regulation in forward mode.
// - Bit 3 shows input or pin current loop; boost current loop in boost.
// - Bit 2 shows input voltage loop; boost voltage loop in boost or backup.
// - Bit 1 shows charge safety timer expiry.
// - Bit 0 shows serial watchdog expiry.
// - Phase and adapter status at 0x1e resets zero; bits 7:5 read zero.
// - Charge phase bits 4:3 report idle, constant current, taper, top-off.
// - Adapter type bits 2:0 encode source; 110b reserved.
// - Adapter type reads 111b in boost output mode.
// - Variant without detection reports 100b for an unknown adapter.
// - Fault status at 0x1f resets zero; fault bits 7:3, zone bits 2:0.
// - Fault bits: input, battery, system rail, boost path, thermal shutdown.
// - Zone field: normal, cold, hot, cool, warm, pre-cool, pre-warm, bias fault.
// - Software register reset restores profile fields to defaults.
//
module csn_regs #(
   parameter bit HAS_ADAPTER_DETECT = 1'b1
) (
   input  wire logic       clock,
   input  wire logic       rst,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   input  wire logic       soft_reg_reset,
   // Live conditions
   input  wire logic       adc_oneshot_done,
   input  wire logic       adc_continuous_mode,
   input  wire logic       die_thermal_reg_active,
   input  wire logic       min_system_reg_active,
   input  wire logic       boost_output_mode,
   input  wire logic       backup_mode,
   input  wire logic       input_current_limit_loop,
   input  wire logic       current_limit_pin,
   input  wire logic       boost_current_limit,
   input  wire logic       input_voltage_limit_loop,
   input  wire logic       boost_voltage_target,
   input  wire logic       safety_timer_expired,
   input  wire logic       watchdog_expired,
   input  wire logic [1:0] charge_phase,
   input  wire logic [2:0] adapter_type,
   input  wire logic       auto_source_detect_en,
   input  wire logic       adapter_present,
   input  wire logic       input_fault,
   input  wire logic       battery_fault,
   input  wire logic       system_rail_fault,
   input  wire logic       boost_path_fault,
   input  wire logic       thermal_shutdown_active,
   input  wire logic [2:0] temperature_zone,
   // Profile outcome
   output logic      [8:0] voltage_drop_mv,
   output logic      [6:0] current_scale_pct,
   output logic            charge_suspend,
   output logic      [7:0] profile_value
);

   localparam int NSYNC = 28;

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] live;

   assign raw_in = {adc_oneshot_done, adc_continuous_mode, die_thermal_reg_active,
                    min_system_reg_active, boost_output_mode, backup_mode,
                    input_current_limit_loop, current_limit_pin, boost_current_limit,
                    input_voltage_limit_loop, boost_voltage_target, safety_timer_expired,
                    watchdog_expired, charge_phase, adapter_type, auto_source_detect_en,
                    adapter_present, input_fault, battery_fault, system_rail_fault,
                    boost_path_fault, thermal_shutdown_active, temperature_zone};

   csn_sync #(
      .WIDTH   (NSYNC)
   ) u_sync (
      .clock    (clock),
      .rst      (rst),
      .async_in (raw_in),
      .sync_out (live)
   );

   logic       s_adc_done;
   logic       s_adc_cont;
   logic       s_die_therm;
   logic       s_min_sys;
   logic       s_boost;
   logic       s_backup;
   logic       s_in_cur;
   logic       s_pin_cur;
   logic       s_boost_cur;
   logic       s_in_volt;
   logic       s_boost_volt;
   logic       s_safety;
   logic       s_watchdog;
   logic [1:0] s_phase;
   logic [2:0] s_adapter;
   logic       s_auto_det;
   logic       s_present;
   logic [4:0] s_faults;
   logic [2:0] s_zone;

   assign {s_adc_done, s_adc_cont, s_die_therm, s_min_sys, s_boost, s_backup,
           s_in_cur, s_pin_cur, s_boost_cur, s_in_volt, s_boost_volt, s_safety,
           s_watchdog, s_phase, s_adapter, s_auto_det, s_present, s_faults, s_zone} = live;

   // ----------------------------------------------------------------
   // Thermistor profile register
   // ----------------------------------------------------------------
   logic       sym_q;
   logic [1:0] prewarm_voltage_sel_q;
   logic [1:0] prewarm_current_sel_q;
   logic [1:0] precool_current_sel_q;
   logic       profile_wr;

   assign profile_wr = reg_wr && (reg_addr == csn_pkg::OFS_THERMISTOR_PROFILE_CONTROL);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sym_q                 <= csn_pkg::SYM_DEFAULT;
         prewarm_voltage_sel_q <= csn_pkg::SEL_DEFAULT;
         prewarm_current_sel_q <= csn_pkg::SEL_DEFAULT;
         precool_current_sel_q <= csn_pkg::SEL_DEFAULT;
      end else if (soft_reg_reset) begin
         sym_q                 <= csn_pkg::SYM_DEFAULT;
         prewarm_voltage_sel_q <= csn_pkg::SEL_DEFAULT;
         prewarm_current_sel_q <= csn_pkg::SEL_DEFAULT;
         precool_current_sel_q <= csn_pkg::SEL_DEFAULT;
      end else if (profile_wr) begin
         sym_q                 <= reg_wdata[csn_pkg::POS_SYM];
         prewarm_voltage_sel_q <= reg_wdata[csn_pkg::POS_PREWARM_V_HI:csn_pkg::POS_PREWARM_V_LO];
         prewarm_current_sel_q <= reg_wdata[csn_pkg::POS_PREWARM_I_HI:csn_pkg::POS_PREWARM_I_LO];
         precool_current_sel_q <= reg_wdata[csn_pkg::POS_PRECOOL_I_HI:csn_pkg::POS_PRECOOL_I_LO];
      end
   end

   assign profile_value = {1'b0, sym_q, prewarm_voltage_sel_q, prewarm_current_sel_q, precool_current_sel_q};

   // ----------------------------------------------------------------
   // Zone adjustment
   // ----------------------------------------------------------------
   function automatic logic [8:0] drop_of(input logic [1:0] sel);
      unique case (sel)
         csn_pkg::SEL_SUSPEND: drop_of = csn_pkg::DROP_300_MV;
         csn_pkg::SEL_LOW:     drop_of = csn_pkg::DROP_200_MV;
         csn_pkg::SEL_MID:     drop_of = csn_pkg::DROP_100_MV;
         default:              drop_of = csn_pkg::DROP_NONE;
      endcase
   endfunction

   function automatic logic [6:0] pct_of(input logic [1:0] sel);
      unique case (sel)
         csn_pkg::SEL_SUSPEND: pct_of = csn_pkg::PCT_0;
         csn_pkg::SEL_LOW:     pct_of = csn_pkg::PCT_20;
         csn_pkg::SEL_MID:     pct_of = csn_pkg::PCT_40;
         default:              pct_of = csn_pkg::PCT_100;
      endcase
   endfunction

   logic [8:0] voltage_drop_d;
   logic [6:0] current_scale_d;
   logic       charge_suspend_d;

   always_comb begin
      voltage_drop_d   = csn_pkg::DROP_NONE;
      current_scale_d  = csn_pkg::PCT_100;
      charge_suspend_d = 1'b0;
      if (s_zone == csn_pkg::ZONE_PRE_WARM) begin
         voltage_drop_d   = drop_of(prewarm_voltage_sel_q);
         current_scale_d  = pct_of(prewarm_current_sel_q);
         charge_suspend_d = (prewarm_current_sel_q == csn_pkg::SEL_SUSPEND);
      end else if (s_zone == csn_pkg::ZONE_PRE_COOL) begin
         voltage_drop_d   = sym_q ? drop_of(prewarm_voltage_sel_q) : csn_pkg::DROP_NONE;
         current_scale_d  = pct_of(precool_current_sel_q);
         charge_suspend_d = (precool_current_sel_q == csn_pkg::SEL_SUSPEND);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         voltage_drop_mv   <= csn_pkg::DROP_NONE;
         current_scale_pct <= csn_pkg::PCT_100;
         charge_suspend    <= 1'b0;
      end else begin
         voltage_drop_mv   <= voltage_drop_d;
         current_scale_pct <= current_scale_d;
         charge_suspend    <= charge_suspend_d;
      end
   end

   // ----------------------------------------------------------------
   // Live status capture
   // ----------------------------------------------------------------
   logic [7:0] cond_d;
   logic [7:0] cond_q;
   logic [2:0] adapter_d;
   logic [7:0] phase_q;
   logic [7:0] fault_q;

   always_comb begin
      cond_d = csn_pkg::RST_STATUS;
      cond_d[csn_pkg::POS_ADC_DONE]   = s_adc_done && !s_adc_cont;
      cond_d[csn_pkg::POS_DIE_THERM]  = s_die_therm;
      cond_d[csn_pkg::POS_MIN_SYS]    = s_min_sys && !s_boost;
      cond_d[csn_pkg::POS_IN_CURRENT] = s_boost ? s_boost_cur : (s_in_cur || s_pin_cur);
      cond_d[csn_pkg::POS_IN_VOLTAGE] = (s_boost || s_backup) ? s_boost_volt : s_in_volt;
      cond_d[csn_pkg::POS_SAFETY]     = s_safety;
      cond_d[csn_pkg::POS_WATCHDOG]   = s_watchdog;
   end

   always_comb begin
      if (s_boost) begin
         adapter_d = csn_pkg::ADAPTER_BOOST;
      end else if (!HAS_ADAPTER_DETECT) begin
         adapter_d = s_present ? csn_pkg::ADAPTER_UNKNOWN : csn_pkg::ADAPTER_NONE;
      end else if (!s_auto_det || s_adapter == csn_pkg::ADAPTER_RESERVED
                   || s_adapter == csn_pkg::ADAPTER_BOOST) begin
         adapter_d = csn_pkg::ADAPTER_NONE;
      end else begin
         adapter_d = s_adapter;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cond_q  <= csn_pkg::RST_STATUS;
         phase_q <= csn_pkg::RST_STATUS;
         fault_q <= csn_pkg::RST_STATUS;
      end else begin
         cond_q  <= cond_d;
         phase_q <= {3'h0, s_phase, adapter_d};
         fault_q <= {s_faults, s_zone};
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   logic [7:0] rdata_d;

   always_comb begin
      unique case (reg_addr)
         csn_pkg::OFS_THERMISTOR_PROFILE_CONTROL: rdata_d = profile_value;
         csn_pkg::OFS_CHARGER_CONDITION_STATUS:   rdata_d = cond_q;
         csn_pkg::OFS_CHARGE_PHASE_ADAPTER:       rdata_d = phase_q;
         csn_pkg::OFS_FAULT_CONDITION_STATUS:     rdata_d = fault_q;
         default:                                 rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rdata_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   profile_soft_reset_a : assert property (
      soft_reg_reset |=> (profile_value == csn_pkg::RST_THERMISTOR_PROFILE))
      else $error("Profile not restored by register reset");

   status_write_ignored_a : assert property (
      (reg_wr && reg_addr != csn_pkg::OFS_THERMISTOR_PROFILE_CONTROL && !soft_reg_reset)
      |=> $stable(profile_value))
      else $error("Write to status register changed profile");

   cond_reserved_zero_a : assert property (
      (reg_rd && reg_addr == csn_pkg::OFS_CHARGER_CONDITION_STATUS) |=> (reg_rvalid && !reg_rdata[7]))
      else $error("Reserved condition bit read nonzero");

   phase_reserved_zero_a : assert property (
      (reg_rd && reg_addr == csn_pkg::OFS_CHARGE_PHASE_ADAPTER) |=> (reg_rdata[7:5] == 3'h0))
      else $error("Reserved phase bits read nonzero");

   adc_continuous_zero_a : assert property (
      s_adc_cont |=> !cond_q[csn_pkg::POS_ADC_DONE])
      else $error("Conversion done set in continuous mode");

   boost_adapter_code_a : assert property (
      s_boost |=> (phase_q[2:0] == csn_pkg::ADAPTER_BOOST))
      else $error("Adapter code not boost in boost mode");

   prewarm_drop_300_a : assert property (
      (s_zone == csn_pkg::ZONE_PRE_WARM && prewarm_voltage_sel_q == csn_pkg::SEL_SUSPEND)
      |=> (voltage_drop_mv == csn_pkg::DROP_300_MV))
      else $error("Prewarm voltage drop wrong");

   prewarm_suspend_a : assert property (
      (s_zone == csn_pkg::ZONE_PRE_WARM && prewarm_current_sel_q == csn_pkg::SEL_SUSPEND)
      |=> (charge_suspend && current_scale_pct == csn_pkg::PCT_0))
      else $error("Prewarm suspend not applied");

   precool_scale_a : assert property (
      (s_zone == csn_pkg::ZONE_PRE_COOL && precool_current_sel_q == csn_pkg::SEL_MID)
      |=> (current_scale_pct == csn_pkg::PCT_40 && !charge_suspend))
      else $error("Precool current scale wrong");

   thermal_bit_live_a : assert property (
      s_die_therm |=> cond_q[csn_pkg::POS_DIE_THERM])
      else $error("Thermal regulation bit not set");

   fault_zone_live_a : assert property (
      1'b1 |=> (fault_q == $past({s_faults, s_zone})))
      else $error("Fault register does not follow conditions");

   unknown_adapter_a : assert property (
      (!HAS_ADAPTER_DETECT && !s_boost && s_present) |=> (phase_q[2:0] == csn_pkg::ADAPTER_UNKNOWN))
      else $error("Unknown adapter code missing without detection");

   reserved_adapter_a : assert property (
      (HAS_ADAPTER_DETECT && !s_boost && s_adapter == csn_pkg::ADAPTER_RESERVED)
      |=> (phase_q[2:0] == csn_pkg::ADAPTER_NONE))
      else $error("Reserved adapter code passed through");

   read_answer_a : assert property (
      (reg_rd && reg_addr == csn_pkg::OFS_FAULT_CONDITION_STATUS)
      |=> (reg_rvalid && reg_rdata == $past(fault_q)))
      else $error("Fault read does not show live register");

endmodule

// ==== hdl/csn_pkg.sv ====
/*
 Constants for the charger status and thermistor profile register slice.
 Assumes an 8-bit register port driven by the device serial interface engine.
*/
package csn_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_THERMISTOR_PROFILE_CONTROL = 8'h1c;
   localparam logic [7:0] OFS_CHARGER_CONDITION_STATUS   = 8'h1d;
   localparam logic [7:0] OFS_CHARGE_PHASE_ADAPTER       = 8'h1e;
   localparam logic [7:0] OFS_FAULT_CONDITION_STATUS     = 8'h1f;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_THERMISTOR_PROFILE = 8'h3f;
   localparam logic [7:0] RST_STATUS             = 8'h00;
   localparam logic [1:0] SEL_DEFAULT            = 2'h3;
   localparam logic       SYM_DEFAULT            = 1'h0;

   // ----------------------------------------------------------------
   // Thermistor profile field positions
   // ----------------------------------------------------------------
   localparam int POS_SYM          = 6;
   localparam int POS_PREWARM_V_HI = 5;
   localparam int POS_PREWARM_V_LO = 4;
   localparam int POS_PREWARM_I_HI = 3;
   localparam int POS_PREWARM_I_LO = 2;
   localparam int POS_PRECOOL_I_HI = 1;
   localparam int POS_PRECOOL_I_LO = 0;

   // ----------------------------------------------------------------
   // Status field positions
   // ----------------------------------------------------------------
   localparam int POS_ADC_DONE   = 6;
   localparam int POS_DIE_THERM  = 5;
   localparam int POS_MIN_SYS    = 4;
   localparam int POS_IN_CURRENT = 3;
   localparam int POS_IN_VOLTAGE = 2;
   localparam int POS_SAFETY     = 1;
   localparam int POS_WATCHDOG   = 0;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] ADAPTER_NONE     = 3'h0;
   localparam logic [2:0] ADAPTER_UNKNOWN  = 3'h4;
   localparam logic [2:0] ADAPTER_RESERVED = 3'h6;
   localparam logic [2:0] ADAPTER_BOOST    = 3'h7;

   localparam logic [2:0] ZONE_NORMAL   = 3'h0;
   localparam logic [2:0] ZONE_PRE_COOL = 3'h5;
   localparam logic [2:0] ZONE_PRE_WARM = 3'h6;

   localparam logic [1:0] SEL_SUSPEND = 2'h0;
   localparam logic [1:0] SEL_LOW     = 2'h1;
   localparam logic [1:0] SEL_MID     = 2'h2;

   localparam logic [8:0] DROP_300_MV = 9'h12c;
   localparam logic [8:0] DROP_200_MV = 9'h0c8;
   localparam logic [8:0] DROP_100_MV = 9'h064;
   localparam logic [8:0] DROP_NONE   = 9'h000;

   localparam logic [6:0] PCT_20  = 7'h14;
   localparam logic [6:0] PCT_40  = 7'h28;
   localparam logic [6:0] PCT_100 = 7'h64;
   localparam logic [6:0] PCT_0   = 7'h00;

endpackage

// ==== hdl/csn_sync.sv ====
/*
 Two flip-flop synchroniser for a vector of independent level signals.
 Assumes each bit is a slow level; no bus coherence across bits is implied.
*/
`timescale 1ns/1ps
module csn_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // ----------------------------------------------------------------
   // Two stage capture
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// ==== tb/csn_host.sv ====
/*
 Host side model of the serial engine byte port of the register slice.
 Assumes one shared clock and a read answer exactly one edge after the strobe.
*/
`timescale 1ns/1ps
module csn_host (
   input  wire logic       clock,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   output logic            soft_reg_reset,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   // ----------------------------------------------------------------
   // Idle bus
   // ----------------------------------------------------------------
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
      soft_reg_reset = 1'b0;
   end

   // ----------------------------------------------------------------
   // Byte accesses
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
      v = reg_rvalid;
   endtask

   task automatic soft_reset();
      @(posedge clock);
      soft_reg_reset <= 1'b1;
      @(posedge clock);
      soft_reg_reset <= 1'b0;
   endtask
endmodule

// ==== tb/charger_status_ntc_regs_test.sv ====
/*
 Self-checking bench for the charger status and thermistor profile slice.
 Assumes the byte port contract of the slice and three edges of input latency.
*/
`timescale 1ns/1ps
module charger_status_ntc_regs_test;
   logic        clock;
   logic        rst;
   logic [27:0] live_q;
   logic [7:0]  reg_addr;
   logic        reg_wr;
   logic [7:0]  reg_wdata;
   logic        reg_rd;
   logic        soft_reg_reset;
   logic [7:0]  reg_rdata;
   logic        reg_rvalid;
   logic [7:0]  alt_rdata;
   logic [8:0]  voltage_drop_mv;
   logic [6:0]  current_scale_pct;
   logic        charge_suspend;
   logic [7:0]  profile_value;
   int          err_total;
   int          checked;
   logic [8:0]  drop_t [4] = '{9'h12c, 9'h0c8, 9'h064, 9'h000};
   logic [6:0]  pct_t [4]  = '{7'h00, 7'h14, 7'h28, 7'h64};

   always #4 clock = ~clock;

   // ----------------------------------------------------------------
   // Instances
   // ----------------------------------------------------------------
   csn_host host_u (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .soft_reg_reset(soft_reg_reset), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   csn_regs dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .soft_reg_reset(soft_reg_reset),
      .adc_oneshot_done(live_q[0]), .adc_continuous_mode(live_q[1]), .die_thermal_reg_active(live_q[2]),
      .min_system_reg_active(live_q[3]), .boost_output_mode(live_q[4]), .backup_mode(live_q[5]),
      .input_current_limit_loop(live_q[6]), .current_limit_pin(live_q[7]), .boost_current_limit(live_q[8]),
      .input_voltage_limit_loop(live_q[9]), .boost_voltage_target(live_q[10]),
      .safety_timer_expired(live_q[11]), .watchdog_expired(live_q[12]), .charge_phase(live_q[14:13]),
      .adapter_type(live_q[17:15]), .auto_source_detect_en(live_q[18]), .adapter_present(live_q[19]),
      .input_fault(live_q[20]), .battery_fault(live_q[21]), .system_rail_fault(live_q[22]),
      .boost_path_fault(live_q[23]), .thermal_shutdown_active(live_q[24]), .temperature_zone(live_q[27:25]),
      .voltage_drop_mv(voltage_drop_mv), .current_scale_pct(current_scale_pct),
      .charge_suspend(charge_suspend), .profile_value(profile_value));
   csn_regs #(.HAS_ADAPTER_DETECT(1'b0)) alt_u (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(alt_rdata), .reg_rvalid(),
      .soft_reg_reset(soft_reg_reset), .adc_oneshot_done(live_q[0]), .adc_continuous_mode(live_q[1]),
      .die_thermal_reg_active(live_q[2]), .min_system_reg_active(live_q[3]), .boost_output_mode(live_q[4]),
      .backup_mode(live_q[5]), .input_current_limit_loop(live_q[6]), .current_limit_pin(live_q[7]),
      .boost_current_limit(live_q[8]), .input_voltage_limit_loop(live_q[9]),
      .boost_voltage_target(live_q[10]), .safety_timer_expired(live_q[11]), .watchdog_expired(live_q[12]),
      .charge_phase(live_q[14:13]), .adapter_type(live_q[17:15]), .auto_source_detect_en(live_q[18]),
      .adapter_present(live_q[19]), .input_fault(live_q[20]), .battery_fault(live_q[21]),
      .system_rail_fault(live_q[22]), .boost_path_fault(live_q[23]), .thermal_shutdown_active(live_q[24]),
      .temperature_zone(live_q[27:25]), .voltage_drop_mv(), .current_scale_pct(), .charge_suspend(),
      .profile_value());

   // ----------------------------------------------------------------
   // Expected status images
   // ----------------------------------------------------------------
   function automatic logic [7:0] e1d(input logic [27:0] l);
      return {1'b0, l[0] & ~l[1], l[2], l[3] & ~l[4], l[4] ? l[8] : (l[6] | l[7]),
              (l[4] | l[5]) ? l[10] : l[9], l[11], l[12]};
   endfunction

   function automatic logic [7:0] e1e(input logic [27:0] l, input bit det);
      logic [2:0] ad;
      if (l[4])
         ad = 3'h7;
      else if (!det)
         ad = l[19] ? 3'h4 : 3'h0;
      else if (!l[18] || l[17:15] > 3'h5)
         ad = 3'h0;
      else
         ad = l[17:15];
      return {3'h0, l[14:13], ad};
   endfunction

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      host_u.rd(a, d, v);
      chk({8'h00, v}, 9'h001);
      chk({1'b0, d}, {1'b0, exp});
   endtask

   task automatic stat(input logic [27:0] l);
      @(posedge clock);
      live_q <= l;
      repeat (4) @(posedge clock);
      rdc(8'h1d, e1d(l));
      rdc(8'h1e, e1e(l, 1'b1));
      chk({1'b0, alt_rdata}, {1'b0, e1e(l, 1'b0)});
      rdc(8'h1f, {l[20], l[21], l[22], l[23], l[24], l[27:25]});
      chk({1'b0, alt_rdata}, {1'b0, l[20], l[21], l[22], l[23], l[24], l[27:25]});
   endtask

   task automatic zone(input logic [2:0] z, input logic [1:0] dv, input logic [1:0] di, input logic sus);
      stat({z, 25'h0});
      chk(voltage_drop_mv, drop_t[dv]);
      chk({2'b00, current_scale_pct}, {2'b00, pct_t[di]});
      chk({8'h00, charge_suspend}, {8'h00, sus});
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      logic [1:0] s;
      clock = 1'b0;
      rst = 1'b1;
      live_q = 28'h0;
      err_total = 0;
      checked = 0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      chk({1'b0, profile_value}, 9'h03f);
      zone(3'h0, 2'h3, 2'h3, 1'b0);
      rdc(8'h1c, 8'h3f);
      $display("test reset done");
      for (int i = 0; i < 28; i++)
         stat(28'h1 << i);
      for (int k = 0; k < 16; k++)
         stat({3'(k), 5'(k * 7), k[1], 1'b1, 3'(k), 2'(k), 8'(k * 8'h5b), k[3], 4'(k * 3)});
      $display("test status done");
      for (int c = 0; c < 4; c++) begin
         s = 2'(c);
         host_u.wr(8'h1c, {2'b11, s, s, s});
         rdc(8'h1c, {2'b01, s, s, s});
         chk({1'b0, profile_value}, {3'b001, s, s, s});
         zone(3'h6, s, s, s == 2'h0);
         zone(3'h5, s, s, s == 2'h0);
      end
      host_u.wr(8'h1c, 8'h87);
      zone(3'h5, 2'h3, 2'h3, 1'b0);
      zone(3'h6, 2'h0, 2'h1, 1'b0);
      $display("test profile done");
      for (int a = 8'h1d; a < 8'h21; a++)
         host_u.wr(8'(a), 8'hff);
      stat(28'h0);
      rdc(8'h20, 8'h00);
      rdc(8'h1c, 8'h07);
      host_u.soft_reset();
      rdc(8'h1c, 8'h3f);
      zone(3'h6, 2'h3, 2'h3, 1'b0);
      $display("test write and soft reset done");
      end_of_test();
   end
endmodule
